/* dsl_payload_slot_mapper.sv */
// Payload slot mapper: places user traffic into payload sub-blocks.
// Assumes the frame builder gives one bit_tick per payload bit and marks the
// first bit of each sub-block; the user side keeps data ready when asked.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "slot_mapper_regs.svh"

// Operation
// - Bit mode fills block with contiguous bits
// - Bit order in time equals transmit order
// - Byte mode keeps bytes on slot boundaries
// - Each byte sent LSB first
// - Slot one at block bit zero, ascending
// - Byte mode: no bit slots, 3..35 bytes
// - Unstructured 2M uses bit clear mapping
// - Unaligned 2M: 32 bytes, order kept
// - Unaligned 2M frame offset constant per block
// - Aligned 2M frame starts at block start
// - Aligned: 32 bytes full, fewer fractional
// - ISDN: i bit slots then n bytes
// - Bearer one byte; signalling two bits
// - Four or more accesses share signalling byte
// - One to six accesses, fixed slot counts
// - ISDN frame word is not transported
// - Maintenance functions go over message channel
// - Single shared clock domain for all
// - Lifeline access takes first slots
// - Signalling sent one block after bearers
module dsl_payload_slot_mapper (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame builder timing
  input wire slot_mapper_pkg::line_timing_s line_timing,
  // Mapped bit towards the frame builder
  output slot_mapper_pkg::line_bit_s line_out,
  // Clear channel user stream
  input wire logic user_bit,
  output logic user_bit_take,
  // Byte stream (byte mode, aligned and unaligned 2M, ISDN bearers)
  input wire logic [7:0] user_byte,
  output logic user_byte_take,
  output logic [5:0] user_byte_slot,
  // ISDN signalling pairs, two bits per access
  input wire logic [11:0] isdn_sig_bits,
  output logic isdn_sig_take,
  // Status
  output logic config_error
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic enable_reg; // Link active
  slot_mapper_pkg::map_mode_e mode_reg; // Mapping mode
  logic [2:0] access_reg; // ISDN access count
  logic fast_sig_reg; // Fast signalling uses first bit slot
  logic [5:0] bytes_reg; // Byte slot count n (non-ISDN)
  logic [2:0] bits_reg; // Bit slot count i (non-ISDN)
  logic [31:0] block_count_reg; // Sub-blocks mapped
  logic active_reg; // Mapping runs, started on a block boundary

  // --------------------------------------------------------------------------
  // Slot geometry after mode
  // --------------------------------------------------------------------------
  logic [5:0] eff_bytes; // Byte slots in use
  logic [2:0] eff_bits; // Bit slots in use
  logic geom_bad; // Geometry outside allowed range

  // ISDN byte and bit counts per access number
  function automatic logic [8:0] isdn_geom(input logic [2:0] acc);
    logic [8:0] g;
    g = 9'h000;
    unique case (acc)
      3'h1: g = {6'h02, 3'h2};
      3'h2: g = {6'h04, 3'h4};
      3'h3: g = {6'h06, 3'h6};
      3'h4: g = {6'h09, 3'h0};
      3'h5: g = {6'h0B, 3'h2};
      3'h6: g = {6'h0D, 3'h4};
      default: g = 9'h000;
    endcase
    return g;
  endfunction : isdn_geom

  // Mode selects the geometry
  always_comb begin
    eff_bytes = bytes_reg;
    eff_bits = 3'h0;
    geom_bad = 1'b0;
    unique case (mode_reg)
      slot_mapper_pkg::MAP_BIT_CLEAR, slot_mapper_pkg::MAP_UNSTRUCT_2M: begin
        // Contiguous bits, block length from n and i
        eff_bits = bits_reg;
      end
      slot_mapper_pkg::MAP_BYTE_CLEAR: begin
        // No bit slots, 3 <= n < 36
        geom_bad = (bytes_reg < `BYTE_SLOT_MIN) || (bytes_reg > `BYTE_SLOT_MAX_CLEAR) || (bits_reg != 3'h0);
      end
      slot_mapper_pkg::MAP_UNALIGNED_2M: begin
        eff_bytes = `BYTE_SLOT_E1;
      end
      slot_mapper_pkg::MAP_ALIGNED_2M: begin
        // Full or fractional frame
        geom_bad = (bytes_reg > `BYTE_SLOT_E1) || (bytes_reg == 6'h00);
      end
      slot_mapper_pkg::MAP_ISDN: begin
        // Table of slot counts per access count
        {eff_bytes, eff_bits} = isdn_geom(access_reg);
        geom_bad = (access_reg == 3'h0) || (access_reg > `ISDN_ACCESS_MAX);
      end
      default: begin
        geom_bad = 1'b1;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Register writes; configuration frozen while enabled
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      mode_reg <= slot_mapper_pkg::MAP_BIT_CLEAR;
      access_reg <= 3'h0;
      fast_sig_reg <= 1'b0;
      bytes_reg <= `GEOM_RESET_BYTES;
      bits_reg <= `GEOM_RESET_BITS;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) begin
        enable_reg <= reg_wdata[`CTRL_ENABLE_BIT];
        // Mode fields only move while the link is idle
        if (!enable_reg) begin
          mode_reg <= slot_mapper_pkg::map_mode_e'(reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
          access_reg <= reg_wdata[`CTRL_ACCESS_MSB:`CTRL_ACCESS_LSB];
          fast_sig_reg <= reg_wdata[`CTRL_FAST_SIG_BIT];
        end
      end else if (reg_addr == `REG_GEOM && !enable_reg) begin
        bytes_reg <= reg_wdata[`GEOM_BYTES_MSB:`GEOM_BYTES_LSB];
        bits_reg <= reg_wdata[`GEOM_BITS_MSB:`GEOM_BITS_LSB];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register reads, data in the following cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: reg_rdata <= {19'h00000, fast_sig_reg, 1'b0, access_reg, 1'b0, mode_reg, 3'h0, enable_reg};
        `REG_GEOM: reg_rdata <= {21'h000000, bits_reg, 2'h0, bytes_reg};
        `REG_STATUS: reg_rdata <= {10'h000, eff_bytes, 5'h00, eff_bits, 6'h00, geom_bad, active_reg};
        `REG_COUNT: reg_rdata <= block_count_reg;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Sub-block position counters
  // --------------------------------------------------------------------------
  logic in_bits_reg; // Currently in the bit-slot area
  logic [2:0] bit_slot_reg; // Bit slot index
  logic [5:0] byte_slot_reg; // Byte slot index
  logic [2:0] bit_in_byte_reg; // Bit within current byte
  logic [7:0] shift_reg; // Byte being sent, LSB first
  logic [11:0] sig_now_reg; // Signalling captured at this block's start, sent in the next block
  logic [11:0] sig_prev_reg; // Signalling captured with last bearers
  logic last_frame_block_reg; // Current block ends a frame
  logic tick;
  logic block_go;

  assign tick = line_timing.bit_tick;
  assign block_go = tick && line_timing.block_start;

  // Start only at a sub-block boundary so offsets stay constant
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (!enable_reg || geom_bad) begin
      active_reg <= 1'b0;
    end else if (block_go) begin
      active_reg <= 1'b1;
    end
  end

  // Next slot position; block_start restarts at bit zero
  logic pos_bits_next;
  always_comb begin
    pos_bits_next = (eff_bits != 3'h0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_bits_reg <= 1'b0;
      bit_slot_reg <= 3'h0;
      byte_slot_reg <= 6'h00;
      bit_in_byte_reg <= 3'h0;
    end else if (block_go) begin
      // First bit of block consumed here: slot one at position zero
      in_bits_reg <= pos_bits_next && (eff_bits != 3'h1);
      bit_slot_reg <= 3'h1;
      byte_slot_reg <= 6'h00;
      bit_in_byte_reg <= pos_bits_next ? 3'h0 : 3'h1;
    end else if (tick && active_reg) begin
      if (in_bits_reg) begin
        // Bit slots first, then bytes
        bit_slot_reg <= bit_slot_reg + 3'h1;
        in_bits_reg <= (bit_slot_reg + 3'h1) != eff_bits;
      end else begin
        bit_in_byte_reg <= bit_in_byte_reg + 3'h1; // Slots ascend
        if (bit_in_byte_reg == 3'h7) begin
          byte_slot_reg <= byte_slot_reg + 6'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Data selection
  // --------------------------------------------------------------------------
  logic cur_is_bit_slot; // This tick falls in the bit-slot area
  logic cur_byte_start; // This tick opens a byte slot
  logic [2:0] cur_bit_slot; // Bit slot index at this tick
  logic is_bit_mode; // Bit-transparent modes

  always_comb begin
    is_bit_mode = (mode_reg == slot_mapper_pkg::MAP_BIT_CLEAR) || (mode_reg == slot_mapper_pkg::MAP_UNSTRUCT_2M);
    if (block_go) begin
      cur_is_bit_slot = pos_bits_next;
      cur_bit_slot = 3'h0;
      cur_byte_start = !pos_bits_next;
    end else begin
      cur_is_bit_slot = in_bits_reg;
      cur_bit_slot = bit_slot_reg;
      cur_byte_start = !in_bits_reg && (bit_in_byte_reg == 3'h0);
    end
  end

  // ISDN bit slot contents: signalling of the previous block
  function automatic logic isdn_bit(input logic [2:0] slot, input logic fast, input logic [11:0] sig);
    logic [2:0] k;
    logic r;
    r = 1'b0;
    k = slot;
    if (fast) begin
      // First bit slot reserved for the fast signalling channel
      k = slot - 3'h1;
      r = (slot == 3'h0) ? 1'b0 : sig[k];
    end else begin
      r = sig[k];
    end
    return r;
  endfunction : isdn_bit

  // Signalling due now; at block start the capture has not yet moved over
  logic [11:0] sig_send;
  assign sig_send = block_go ? sig_now_reg : sig_prev_reg;

  // Shared signalling byte for four or more accesses
  logic [7:0] shared_sig_byte;
  logic shared_sig;
  always_comb begin
    shared_sig = (mode_reg == slot_mapper_pkg::MAP_ISDN) && (access_reg >= `ISDN_SHARED_SIG_MIN);
    // Accesses with bit slots come first; rest fill the shared byte
    if (access_reg == 3'h4) begin
      shared_sig_byte = sig_send[7:0];
    end else if (access_reg == 3'h5) begin
      shared_sig_byte = sig_send[9:2];
    end else begin
      shared_sig_byte = sig_send[11:4];
    end
  end

  // --------------------------------------------------------------------------
  // Output bit stream and user handshakes
  // --------------------------------------------------------------------------
  logic out_data;
  logic take_byte;
  logic take_bit;
  logic [7:0] load_byte;

  always_comb begin
    take_bit = 1'b0;
    take_byte = 1'b0;
    load_byte = user_byte;
    out_data = 1'b0;
    if (is_bit_mode) begin
      // Each payload bit is the next user bit, no gaps
      take_bit = 1'b1;
      out_data = user_bit;
    end else if (cur_is_bit_slot) begin
      // Only ISDN has bit slots; frame word never sent
      out_data = isdn_bit(cur_bit_slot, fast_sig_reg, sig_send);
    end else if (cur_byte_start) begin
      // With four or more accesses the shared signalling byte owns byte slot one
      if (shared_sig && (byte_slot_reg == 6'h00) && !block_go) begin
        load_byte = shared_sig_byte;
      end else if (shared_sig && block_go) begin
        load_byte = shared_sig_byte;
      end else begin
        take_byte = 1'b1;
      end
      out_data = load_byte[0]; // LSB first
    end else begin
      out_data = shift_reg[0];
    end
  end

  // Byte shifter keeps the rest of the current slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
    end else if (tick && (active_reg || block_go)) begin
      shift_reg <= cur_byte_start ? {1'b0, load_byte[7:1]} : {1'b0, shift_reg[7:1]};
    end
  end

  // Signalling captured with the bearers, sent in the next block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sig_now_reg <= 12'h000;
      sig_prev_reg <= 12'h000;
      last_frame_block_reg <= 1'b0;
    end else if (block_go) begin
      // Next block after a frame's last one is the next frame's first
      sig_prev_reg <= sig_now_reg;
      sig_now_reg <= isdn_sig_bits;
      last_frame_block_reg <= line_timing.frame_last_block;
    end
  end

  // Registered outputs
  logic going;
  assign going = tick && enable_reg && !geom_bad && (active_reg || block_go);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_out <= '0;
      user_bit_take <= 1'b0;
      user_byte_take <= 1'b0;
      user_byte_slot <= 6'h00;
      isdn_sig_take <= 1'b0;
      config_error <= 1'b0;
    end else begin
      line_out.valid <= going;
      line_out.data <= going ? out_data : 1'b0;
      line_out.block_first <= going && block_go;
      user_bit_take <= going && take_bit;
      user_byte_take <= going && take_byte && !is_bit_mode;
      user_byte_slot <= block_go ? 6'h00 : byte_slot_reg;
      isdn_sig_take <= going && block_go && (mode_reg == slot_mapper_pkg::MAP_ISDN);
      config_error <= geom_bad;
    end
  end

  // Sub-block counter for status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      block_count_reg <= 32'h0000_0000;
    end else if (going && block_go) begin
      block_count_reg <= block_count_reg + 32'h0000_0001;
    end
  end

endmodule : dsl_payload_slot_mapper

/* slot_mapper_regs.svh */
// Constants of the payload slot mapper: register offsets, field positions,
// reset values, slot geometry and mode encodings.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SLOT_MAPPER_REGS_SVH
`define SLOT_MAPPER_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word addresses on the plain port)
// ----------------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_GEOM 4'h1
`define REG_STATUS 4'h2
`define REG_COUNT 4'h3

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 6
`define CTRL_ACCESS_LSB 8
`define CTRL_ACCESS_MSB 10
`define CTRL_FAST_SIG_BIT 12
`define GEOM_BYTES_LSB 0
`define GEOM_BYTES_MSB 5
`define GEOM_BITS_LSB 8
`define GEOM_BITS_MSB 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CTRL_RESET 32'h0000_0000
`define GEOM_RESET_BYTES 6'h20
`define GEOM_RESET_BITS 3'h0

// ----------------------------------------------------------------------------
// Slot geometry limits
// ----------------------------------------------------------------------------
`define BYTE_SLOT_MIN 6'h03
`define BYTE_SLOT_MAX_CLEAR 6'h23
`define BYTE_SLOT_MAX_ISDN 6'h24
`define BYTE_SLOT_E1 6'h20
`define BIT_SLOT_MAX 3'h7
`define ISDN_ACCESS_MAX 3'h6
`define ISDN_SHARED_SIG_MIN 3'h4

// ----------------------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------------------
`define MODE_BIT_CLEAR 3'h0
`define MODE_BYTE_CLEAR 3'h1
`define MODE_UNSTRUCT_2M 3'h2
`define MODE_UNALIGNED_2M 3'h3
`define MODE_ALIGNED_2M 3'h4
`define MODE_ISDN 3'h5

`endif

/* slot_mapper_pkg.sv */
// Types shared by the payload slot mapper and its testbench.
// Assumes the constants header sits in the same folder.
`include "slot_mapper_regs.svh"

package slot_mapper_pkg;

  // --------------------------------------------------------------------------
  // Mapping modes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MAP_BIT_CLEAR = 3'h0,
    MAP_BYTE_CLEAR = 3'h1,
    MAP_UNSTRUCT_2M = 3'h2,
    MAP_UNALIGNED_2M = 3'h3,
    MAP_ALIGNED_2M = 3'h4,
    MAP_ISDN = 3'h5
  } map_mode_e;

  // --------------------------------------------------------------------------
  // Slot position inside the sub-block
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    POS_IDLE = 2'h0,
    POS_BIT_SLOT = 2'h1,
    POS_BYTE_SLOT = 2'h2
  } slot_pos_e;

  // Frame builder timing strobes
  typedef struct packed {
    logic bit_tick;
    logic block_start;
    logic frame_last_block;
  } line_timing_s;

  // One mapped payload bit towards the frame builder
  typedef struct packed {
    logic valid;
    logic data;
    logic block_first;
  } line_bit_s;

endpackage : slot_mapper_pkg

/* dsl_frame_model.sv */
// Frame builder and user source model facing the slot mapper.
// Assumes the bench sets run, pacing gap and the block length.
`timescale 1ns/1ns
module dsl_frame_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench control
  input wire logic run,
  input wire logic gap,
  input wire logic [8:0] blk_len,
  // Towards the mapper
  output slot_mapper_pkg::line_timing_s line_timing,
  output logic user_bit,
  output logic [7:0] user_byte,
  output logic [11:0] isdn_sig_bits
);
  logic [8:0] pos_reg; // Bit position in block
  logic [1:0] blk_reg; // Block within frame
  logic [15:0] seq_reg; // Free count feeding user data
  logic tick; // Tick issued at this edge
  assign tick = run && (!gap || seq_reg[0]);
  // User byte changes every cycle; user bit holds only where seq_reg reaches a multiple of 8
  assign user_bit = seq_reg[0] ^ seq_reg[3];
  assign user_byte = seq_reg[7:0] ^ 8'hA5;
  assign isdn_sig_bits = seq_reg[11:0] ^ 12'h9C3;
  // Ticks stand still while stopped and the position restarts at zero; block length is blk_len
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_timing <= '0;
      pos_reg <= 9'h000;
      blk_reg <= 2'h0;
      seq_reg <= 16'h0000;
    end else begin
      seq_reg <= seq_reg + 16'h0001;
      line_timing.bit_tick <= tick;
      line_timing.block_start <= tick && (pos_reg == 9'h000);
      line_timing.frame_last_block <= tick && (pos_reg == 9'h000) && (blk_reg == 2'h3);
      if (!run) begin
        pos_reg <= 9'h000;
      end else if (tick) begin
        pos_reg <= (pos_reg == blk_len - 9'h001) ? 9'h000 : pos_reg + 9'h001;
        blk_reg <= blk_reg + {1'b0, pos_reg == 9'h000};
      end
    end
  end
endmodule : dsl_frame_model

/* dsl_payload_slot_mapper_sva.sv */
// Checker of the payload slot mapper, bound to its ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
module slot_mapper_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timing and mapped bits
  input wire slot_mapper_pkg::line_timing_s line_timing,
  input wire slot_mapper_pkg::line_bit_s line_out,
  // User side
  input wire logic user_bit,
  input wire logic user_bit_take,
  input wire logic [7:0] user_byte,
  input wire logic user_byte_take,
  input wire logic [5:0] user_byte_slot,
  input wire logic isdn_sig_take,
  input wire logic config_error
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Byte slot opened past the first slot
  sequence byte_open_s;
    user_byte_take && (user_byte_slot != 6'h00);
  endsequence
  // Remaining seven bits of a byte
  sequence byte_rest_s;
    !user_byte_take [*7];
  endsequence
  out_tick_a: assert property (line_out.valid |-> $past(line_timing.bit_tick))
    else $error("output without tick");
  first_mark_a: assert property (line_out.block_first |-> line_out.valid && $past(line_timing.block_start))
    else $error("block mark misplaced");
  bit_order_a: assert property (user_bit_take |-> line_out.valid && (line_out.data == $past(user_bit)))
    else $error("user bit out of order");
  byte_lsb_a: assert property (byte_open_s |-> line_out.valid && (line_out.data == $past(user_byte[0])))
    else $error("byte not lsb first");
  slot_one_a: assert property (user_byte_take && line_out.block_first |-> user_byte_slot == 6'h00)
    else $error("first slot not at block start");
  byte_gap_a: assert property (user_byte_take |=> byte_rest_s)
    else $error("byte slots overlap");
  slot_range_a: assert property (user_byte_take |-> user_byte_slot <= 6'h23)
    else $error("byte slot index too high");
  sig_block_a: assert property (isdn_sig_take |-> $past(line_timing.block_start) && $past(line_timing.bit_tick))
    else $error("signalling taken off block start");
  err_idle_a: assert property (config_error |-> !line_out.valid)
    else $error("output with illegal geometry");
  take_excl_a: assert property (user_bit_take |-> !user_byte_take && !isdn_sig_take)
    else $error("bit and byte taken together");
endmodule : slot_mapper_sva

bind dsl_payload_slot_mapper slot_mapper_sva chk (.clk_sys, .rst_n, .line_timing, .line_out, .user_bit,
  .user_bit_take, .user_byte, .user_byte_take, .user_byte_slot, .isdn_sig_take, .config_error);

/* dsl_payload_slot_mapper_tb.sv */
// Testbench of the payload slot mapper: register tasks and block checks.
// Assumes the frame model and the checker are compiled before it.
`timescale 1ns/1ns
`include "slot_mapper_regs.svh"
module dsl_payload_slot_mapper_tb;
  logic clk_sys, rst_n, reg_wr, reg_rd, run, gap, bit_prev;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] blk_len;
  slot_mapper_pkg::line_timing_s line_timing;
  slot_mapper_pkg::line_bit_s line_out;
  logic user_bit, user_bit_take, user_byte_take, isdn_sig_take, config_error;
  logic [7:0] user_byte, byte_prev;
  logic [5:0] user_byte_slot;
  logic [11:0] isdn_sig_bits, sig_cur, sig_last;
  int mismatches, tests_run, cycles;
  dsl_payload_slot_mapper uut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_timing, .line_out, .user_bit, .user_bit_take, .user_byte, .user_byte_take, .user_byte_slot,
    .isdn_sig_bits, .isdn_sig_take, .config_error);
  dsl_frame_model fb (.clk_sys, .rst_n, .run, .gap, .blk_len, .line_timing, .user_bit, .user_byte,
    .isdn_sig_bits);
  // ------------------------------
  // Clock, capture and timeout
  // ------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Keep what the mapper sampled at each edge
  always @(posedge clk_sys) begin
    byte_prev <= user_byte;
    bit_prev <= user_bit;
    cycles <= cycles + 1;
    if (line_timing.bit_tick && line_timing.block_start) begin
      sig_last <= sig_cur;
      sig_cur <= isdn_sig_bits;
    end
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task rchk(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge clk_sys);
  endtask : rchk
  // Stop the link, set geometry and mode, then start it
  task cfg(input logic [2:0] mode, input logic [2:0] acc, input logic [2:0] zi, input logic [5:0] n,
      input logic [8:0] len);
    run <= 1'b0;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_GEOM, {21'h0, zi, 2'h0, n});
    wr(`REG_CTRL, {21'h0, acc, 1'b0, mode, 3'h0, 1'b1});
    blk_len <= len;
    run <= 1'b1;
  endtask : cfg
  // Follow nb blocks of zi bit slots and nby byte slots, or 20 clear bits
  // sh counts shared signalling bytes checked as leading signalling bits
  task run_blocks(input int nb, input int zi, input int nby, input bit bits_only, input int sh = 0);
    int p, g, len;
    logic [7:0] cur_b;
    len = bits_only ? 20 : zi + 8 * nby;
    g = 0;
    @(posedge clk_sys);
    #1;
    while (!(line_out.valid === 1'b1 && line_out.block_first === 1'b1) && g < 1200) begin
      @(posedge clk_sys);
      #1 g++;
    end
    check(g < 1200, 1);
    for (int b = 0; b < nb; b++) begin
      for (p = 0; p < len; p++) begin
        g = 0;
        while (line_out.valid !== 1'b1 && g < 4) begin
          @(posedge clk_sys);
          #1 g++;
        end
        check(line_out.block_first, p == 0);
        if (bits_only) check({user_bit_take, line_out.data}, {1'b1, bit_prev});
        else if (p < zi) begin
          if (b > 0) check(line_out.data, sig_last[p]);
        end else begin
          if ((p - zi) % 8 == 0) begin
            cur_b = byte_prev;
            check({user_byte_take, user_byte_slot}, {1'b1, 6'((p - zi) / 8 + sh)});
          end
          check(line_out.data, cur_b[(p - zi) % 8]);
        end
        @(posedge clk_sys);
        #1;
      end
    end
    @(posedge clk_sys);
  endtask : run_blocks
  // Illegal geometry raises the error flag and keeps the link quiet
  task err_case(input logic [2:0] zi, input logic [5:0] n);
    cfg(3'h1, 3'h0, zi, n, 9'd100);
    repeat (40) @(posedge clk_sys);
    #1 check({config_error, line_out.valid}, 2'b10);
    @(posedge clk_sys);
  endtask : err_case
  task test_done;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, run, gap, reg_addr, reg_wdata} = '0;
    {mismatches, tests_run, cycles} = '0;
    blk_len = 9'd24;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk(`REG_CTRL, 32'h0);
    rchk(`REG_GEOM, 32'h0000_0020);
    rchk(4'hF, 32'h0);
    $display("register reset test done");
    cfg(3'h1, 3'h0, 3'h0, 6'd3, 9'd24);
    run_blocks(3, 0, 3, 0);
    wr(`REG_GEOM, 32'h5);
    rchk(`REG_GEOM, 32'h3);
    run_blocks(1, 0, 3, 0);
    gap <= 1'b1;
    cfg(3'h1, 3'h0, 3'h0, 6'd35, 9'd280);
    run_blocks(2, 0, 35, 0);
    gap <= 1'b0;
    err_case(3'h0, 6'd36);
    err_case(3'h1, 6'd8);
    $display("byte mode test done");
    cfg(3'h0, 3'h0, 3'h0, 6'd32, 9'd20);
    run_blocks(2, 0, 0, 1);
    cfg(3'h2, 3'h0, 3'h0, 6'd32, 9'd20);
    run_blocks(2, 0, 0, 1);
    $display("clear bit test done");
    cfg(3'h3, 3'h0, 3'h0, 6'd5, 9'd256);
    run_blocks(1, 0, 32, 0);
    rchk(`REG_STATUS, 32'h0020_0001);
    cfg(3'h4, 3'h0, 3'h0, 6'd32, 9'd256);
    run_blocks(1, 0, 32, 0);
    cfg(3'h4, 3'h0, 3'h0, 6'd5, 9'd40);
    run_blocks(2, 0, 5, 0);
    $display("leased line test done");
    cfg(3'h5, 3'h2, 3'h4, 6'd4, 9'd36);
    run_blocks(3, 4, 4, 0);
    cfg(3'h5, 3'h3, 3'h6, 6'd6, 9'd54);
    run_blocks(3, 6, 6, 0);
    rchk(`REG_STATUS, 32'h0006_0601);
    cfg(3'h5, 3'h4, 3'h0, 6'd9, 9'd72);
    run_blocks(3, 8, 8, 0, 1);
    $display("isdn test done");
    test_done();
  end
endmodule : dsl_payload_slot_mapper_tb
